// >>> smd_pkg.sv
// package: address map constants and target selects for the system address map decoder
package smd_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	// reset memory map
	localparam logic [31:0] WIN_BASE_RST = 32'h03FF0000;
	localparam logic [31:0] WIN_SIZE = 32'h00010000;
	localparam logic [31:0] FLASH0_BASE_RST = 32'h00000000;
	localparam logic [31:0] FLASH0_LIMIT_RST = 32'h01FFFFFF;
	// window offsets, first and last word of each group
	localparam logic [15:0] SYS_LO = 16'h0000;
	localparam logic [15:0] SYS_HI = 16'h0004;
	localparam logic [15:0] PCI_LO = 16'h2000;
	localparam logic [15:0] PCI_HI = 16'h2224;
	localparam logic [15:0] MEM_LO = 16'h4000;
	localparam logic [15:0] MEM_HI = 16'h4040;
	localparam logic [15:0] WDMA_LO = 16'h6000;
	localparam logic [15:0] WDMA_HI = 16'h60FC;
	localparam logic [15:0] LDMA_LO = 16'h8000;
	localparam logic [15:0] LDMA_HI = 16'h80FC;
	localparam logic [15:0] INTC_LO = 16'hE200;
	localparam logic [15:0] INTC_HI = 16'hE234;
	localparam logic [15:0] TMR_LO = 16'hE400;
	localparam logic [15:0] TMR_HI = 16'hE410;
	localparam logic [15:0] GPIO_LO = 16'hE600;
	localparam logic [15:0] GPIO_HI = 16'hE608;
	localparam logic [15:0] SWC_LO = 16'hE800;
	localparam logic [15:0] SWC_HI = 16'hE850;
	localparam logic [15:0] MISC_LO = 16'hEA00;
	localparam logic [15:0] MISC_HI = 16'hEA18;
	localparam int NUM_GROUPS = 10;
	// one-hot group select bit positions
	localparam int G_SYS = 0;
	localparam int G_PCI = 1;
	localparam int G_MEM = 2;
	localparam int G_WDMA = 3;
	localparam int G_LDMA = 4;
	localparam int G_INTC = 5;
	localparam int G_TMR = 6;
	localparam int G_GPIO = 7;
	localparam int G_SWC = 8;
	localparam int G_MISC = 9;
	// boot bank width strap codes
	localparam logic [1:0] STRAP_RSVD = 2'h0;
	localparam logic [1:0] STRAP_BYTE = 2'h1;
	localparam logic [1:0] STRAP_HALF = 2'h2;
	localparam logic [1:0] STRAP_WORD = 2'h3;
	typedef enum logic [1:0] {SMD_W_RSVD, SMD_W_BYTE, SMD_W_HALF, SMD_W_WORD} smd_width_e;
	typedef enum {SMD_ST_STRAP, SMD_ST_RUN} smd_state_e;
endpackage : smd_pkg

// >>> smd_range_match.sv
// module: one inclusive offset range comparator for a register group
`timescale 1ns/100ps
`default_nettype none
module smd_range_match #(
	parameter logic [15:0] LO = 16'h0000,
	parameter logic [15:0] HI = 16'h0000
) (
	// offset inside the window
	input wire logic [15:0] offset,
	// match result
	output logic hit
);
	assign hit = (offset >= LO) && (offset <= HI);
endmodule : smd_range_match
`default_nettype wire

// >>> smd_decoder.sv
// module: system address map decoder, window relocation and register group routing
// What this block does
// - at reset boot flash bank maps from zero, window sits at top, middle unconfigured
// - window base resets to 0x03FF0000
// - software may move window and remap banks; later accesses use new map
// - window covers one contiguous 64KB block from its current base
// - in guest mode external host sees bridge subset; window still reaches all
// - route 0x2000-0x2224 to bridge, 0x4000-0x4040 to memory controller
// - route 0xE200-0xE234 to interrupt controller, 0xE400-0xE410 to timer
// - route 0x0000-0x0004 system, 0x6000-0x60FC wide DMA, 0x8000-0x80FC local DMA
// - route 0xE600-0xE608 GPIO, 0xE800-0xE850 switch, 0xEA00-0xEA18 misc
// - boot bank width caught from two straps on the first clock after reset release; 00 reserved
`timescale 1ns/100ps
`default_nettype none
module smd_decoder #(
	parameter int GUEST_LO = 16'h2000,
	parameter int GUEST_HI = 16'h20FC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// strap
	input wire logic [1:0] bootBankWidthStrap,
	// remap control from the system registers
	input wire logic remapWe,
	input wire logic [31:0] newWinBase,
	input wire logic [31:0] newFlashBase,
	input wire logic [31:0] newFlashLimit,
	// local bus request
	input wire logic busValid,
	input wire logic busWrite,
	input wire logic [31:0] busAddr,
	input wire logic [3:0] busByteEn,
	input wire logic [31:0] busWdata,
	// external host request in guest mode
	input wire logic guestMode,
	input wire logic hostValid,
	input wire logic [15:0] hostOffset,
	// read data returned by the register groups
	input wire logic [31:0] groupRdata,
	// routed request
	output logic [9:0] groupSel,
	output logic [15:0] groupOffset,
	output logic groupWrite,
	output logic [31:0] groupWdata,
	output logic hostSel,
	output logic flashSel,
	// answer to the master
	output logic busAck,
	output logic busErr,
	output logic [31:0] busRdata,
	// map state
	output logic [31:0] winBase,
	output logic [1:0] bootBankWidth,
	output logic bootWidthBad
);
	////////////////////////////////////////////////////////////////////////////////
	// map state
	smd_pkg::smd_state_e state, next_state;
	logic [31:0] flashBase, flashLimit, next_winBase, next_flashBase, next_flashLimit;
	logic [1:0] next_bootBankWidth;
	logic next_bootWidthBad;

	always_comb begin
		next_state = state;
		next_winBase = winBase;
		next_flashBase = flashBase;
		next_flashLimit = flashLimit;
		next_bootBankWidth = bootBankWidth;
		next_bootWidthBad = bootWidthBad;
		unique case (state)
			smd_pkg::SMD_ST_STRAP: begin
				// straps caught on the first clock after reset release, never under reset
				next_bootBankWidth = bootBankWidthStrap;
				next_bootWidthBad = (bootBankWidthStrap == smd_pkg::STRAP_RSVD);
				next_state = smd_pkg::SMD_ST_RUN;
			end
			smd_pkg::SMD_ST_RUN: begin
				if (remapWe) begin
					// base kept 64KB aligned so the window stays one block
					next_winBase = {newWinBase[31:16], 16'h0000};
					next_flashBase = newFlashBase;
					next_flashLimit = newFlashLimit;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state <= smd_pkg::SMD_ST_STRAP;
			winBase <= smd_pkg::WIN_BASE_RST;
			flashBase <= smd_pkg::FLASH0_BASE_RST;
			flashLimit <= smd_pkg::FLASH0_LIMIT_RST;
			bootBankWidth <= smd_pkg::STRAP_RSVD;
			bootWidthBad <= 1'b0;
		end else begin
			state <= next_state;
			winBase <= next_winBase;
			flashBase <= next_flashBase;
			flashLimit <= next_flashLimit;
			bootBankWidth <= next_bootBankWidth;
			bootWidthBad <= next_bootWidthBad;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// decode
	logic inWin, wordOk, inFlash;
	logic [15:0] offs;
	logic [9:0] hits;
	localparam logic [15:0] LOS [10] = '{smd_pkg::SYS_LO, smd_pkg::PCI_LO, smd_pkg::MEM_LO,
		smd_pkg::WDMA_LO, smd_pkg::LDMA_LO, smd_pkg::INTC_LO, smd_pkg::TMR_LO,
		smd_pkg::GPIO_LO, smd_pkg::SWC_LO, smd_pkg::MISC_LO};
	localparam logic [15:0] HIS [10] = '{smd_pkg::SYS_HI, smd_pkg::PCI_HI, smd_pkg::MEM_HI,
		smd_pkg::WDMA_HI, smd_pkg::LDMA_HI, smd_pkg::INTC_HI, smd_pkg::TMR_HI,
		smd_pkg::GPIO_HI, smd_pkg::SWC_HI, smd_pkg::MISC_HI};

	assign inWin = (busAddr[31:16] == winBase[31:16]);
	assign offs = busAddr[15:0];
	// partial or misaligned window accesses are refused rather than half-served
	assign wordOk = (busAddr[1:0] == 2'h0) && (busByteEn == 4'hF);
	// window wins over a bank programmed to overlap it
	assign inFlash = !inWin && (busAddr >= flashBase) && (busAddr <= flashLimit);

	genvar gi;
	generate
		for (gi = 0; gi < smd_pkg::NUM_GROUPS; gi++) begin : g_match
			smd_range_match #(.LO(LOS[gi]), .HI(HIS[gi])) u_match (
				.offset(offs),
				.hit(hits[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// routed request and answer
	logic [9:0] next_groupSel;
	logic [15:0] next_groupOffset, gOff;
	logic next_groupWrite, next_hostSel, next_flashSel, next_busAck, next_busErr;
	logic [31:0] next_groupWdata, next_busRdata;
	logic pend, next_pend;

	assign gOff = hostOffset;

	always_comb begin
		next_groupSel = '0;
		next_groupOffset = groupOffset;
		next_groupWrite = 1'b0;
		next_groupWdata = groupWdata;
		next_hostSel = 1'b0;
		next_flashSel = 1'b0;
		next_busAck = 1'b0;
		next_busErr = 1'b0;
		next_busRdata = '0;
		if (pend) begin
			// group answers one cycle after select; unmapped returns zero
			next_busAck = 1'b1;
			next_busRdata = (|groupSel) ? groupRdata : '0;
		end else if (busValid && state == smd_pkg::SMD_ST_RUN && !busAck) begin
			if (inWin && wordOk && (|hits)) begin
				next_groupSel = hits;
				next_groupOffset = offs;
				next_groupWrite = busWrite;
				next_groupWdata = busWdata;
			end else if (inFlash) begin
				next_flashSel = 1'b1;
				next_busAck = 1'b1;
			end else begin
				next_busAck = 1'b1;
				next_busErr = inWin && !wordOk;
			end
		end else if (guestMode && hostValid && state == smd_pkg::SMD_ST_RUN) begin
			// host only reaches the exposed bridge subset
			if (gOff >= GUEST_LO[15:0] && gOff <= GUEST_HI[15:0]) begin
				next_groupSel[smd_pkg::G_PCI] = 1'b1;
				next_groupOffset = gOff;
				next_hostSel = 1'b1;
			end
		end
		// host grants never wait for an answer, so they leave nothing pending
		next_pend = (|next_groupSel) && !next_hostSel;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			groupSel <= '0;
			groupOffset <= '0;
			groupWrite <= 1'b0;
			groupWdata <= '0;
			hostSel <= 1'b0;
			flashSel <= 1'b0;
			busAck <= 1'b0;
			busErr <= 1'b0;
			busRdata <= '0;
			pend <= 1'b0;
		end else begin
			groupSel <= next_groupSel;
			groupOffset <= next_groupOffset;
			groupWrite <= next_groupWrite;
			groupWdata <= next_groupWdata;
			hostSel <= next_hostSel;
			flashSel <= next_flashSel;
			busAck <= next_busAck;
			busErr <= next_busErr;
			busRdata <= next_busRdata;
			pend <= next_pend;
		end
	end
endmodule : smd_decoder
`default_nettype wire

// >>> smd_decoder_assertions.sv
// checker: port timing relations of the address map decoder
`timescale 1ns/100ps
`default_nettype none
module smd_decoder_chk (
	// watched decoder ports
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [1:0] bootBankWidthStrap,
	input wire logic [9:0] groupSel,
	input wire logic [15:0] groupOffset,
	input wire logic hostSel,
	input wire logic flashSel,
	input wire logic busAck,
	input wire logic busErr,
	input wire logic [31:0] winBase,
	input wire logic [1:0] bootBankWidth
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_base_reset:
	assert property ($rose(rst_n) |-> winBase == 32'h03FF0000) else $error("bad reset base");
	a_strap_catch:
	assert property ($rose(rst_n) |=> bootBankWidth == $past(bootBankWidthStrap)) else $error("strap");
	a_sel_onehot:
	assert property ($onehot0(groupSel)) else $error("several groups selected");
	a_group_ack:
	assert property (groupSel != 10'h000 && !hostSel |=> busAck && !busErr) else $error("no ack");
	a_err_ack:
	assert property (busErr |-> busAck && $past(groupSel) == 10'h000) else $error("bad error");
	a_flash_ack:
	assert property (flashSel |-> busAck && groupSel == 10'h000) else $error("bad flash");
	a_host_bridge:
	assert property (hostSel |-> groupSel == 10'h002) else $error("host off bridge");
	a_timer_span:
	assert property (groupSel[6] |-> groupOffset inside {[16'hE400:16'hE410]}) else $error("timer");
endmodule : smd_decoder_chk
bind smd_decoder smd_decoder_chk chk_u (.sys_clk, .rst_n, .bootBankWidthStrap, .groupSel,
	.groupOffset, .hostSel, .flashSel, .busAck, .busErr, .winBase, .bootBankWidth);
`default_nettype wire

// >>> smd_group_model.sv
// model: register groups answering on the routed request
`timescale 1ns/100ps
`default_nettype none
module smd_group_model (
	// clock and routed request
	input wire logic sys_clk,
	input wire logic [9:0] groupSel,
	input wire logic [15:0] groupOffset,
	// read data
	output logic [31:0] groupRdata
);
	logic [31:0] idle = 32'h0;
	// unselected data churns so a stale value cannot pass for an answer
	always @(posedge sys_clk) idle <= idle + 32'h01010101;
	assign groupRdata = (groupSel != 10'h000) ? {~groupOffset, groupOffset} : ~idle;
endmodule : smd_group_model
`default_nettype wire

// >>> system_address_map_decoder_tb.sv
// testbench: routing, remap, strap and guest checks of the decoder
`timescale 1ns/100ps
`default_nettype none
module system_address_map_decoder_tb;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic remapWe = 1'b0, busValid = 1'b0, busWrite = 1'b0, guestMode = 1'b0, hostValid = 1'b0;
	logic [1:0] strap = 2'h2;
	logic [3:0] busByteEn = 4'hF;
	logic [15:0] hostOffset = 16'h0, groupOffset;
	logic [31:0] newWinBase = 32'h0, busAddr = 32'h0, busWdata = 32'h0, expBase = 32'h03FF0000;
	logic [31:0] expLimit = 32'h01FFFFFF, groupWdata;
	logic [31:0] groupRdata, busRdata, winBase;
	logic [9:0] groupSel, sel;
	logic [1:0] bootBankWidth;
	logic hostSel, busAck, busErr, bootWidthBad, flashSel, groupWrite;
	int fails = 0, n_checks = 0, seed = 90;
	// each entry holds first and last offset of a group, in select order
	logic [31:0] rng [10] = '{32'h00000004, 32'h20002224, 32'h40004040, 32'h600060FC, 32'h800080FC,
		32'hE200E234, 32'hE400E410, 32'hE600E608, 32'hE800E850, 32'hEA00EA18};
	always #5 sys_clk = ~sys_clk;
	smd_decoder dut_u (.sys_clk, .rst_n, .bootBankWidthStrap(strap), .remapWe, .newWinBase,
		.newFlashBase(32'h00000000), .newFlashLimit(32'h00FFFFFF), .busValid, .busWrite, .busAddr,
		.busByteEn, .busWdata, .guestMode, .hostValid, .hostOffset, .groupRdata, .groupSel,
		.groupOffset, .groupWrite, .groupWdata, .hostSel, .flashSel, .busAck, .busErr,
		.busRdata, .winBase, .bootBankWidth, .bootWidthBad);
	smd_group_model model_u (.sys_clk, .groupSel, .groupOffset, .groupRdata);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: saw %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test;
		if (fails == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_of_test
	// bit 10 marks a refused access, bit 11 a window hit, bit 12 a boot bank hit
	function automatic logic [31:0] route(input logic [31:0] a, input logic [3:0] be);
		logic [31:0] r;
		r = 32'h0;
		if (a[31:16] == expBase[31:16]) begin
			r[11] = 1'b1;
			if (a[1:0] != 2'h0 || be != 4'hF) r[10] = 1'b1;
			else for (int g = 0; g < 10; g++) r[g] = a[15:0] >= rng[g][31:16] && a[15:0] <= rng[g][15:0];
		end else r[12] = (a <= expLimit);
		return r;
	endfunction : route
	task automatic acc(input logic [31:0] a, input logic w, input logic [3:0] be);
		logic [31:0] e, wd, gd;
		logic gw;
		e = route(a, be);
		wd = $random(seed);
		gw = 1'b0;
		gd = 32'h0;
		sel = 10'h000;
		@(posedge sys_clk);
		busValid <= 1'b1;
		busAddr <= a;
		busWrite <= w;
		busByteEn <= be;
		busWdata <= wd;
		for (int i = 0; i < 8 && busAck !== 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
			sel |= groupSel;
			if (groupSel != 10'h000) begin
				gw = groupWrite;
				gd = groupWdata;
			end
		end
		chk(busAck, 1'b1);
		chk(sel, e[9:0]);
		chk(busErr, e[10]);
		chk(flashSel, e[12]);
		if (e[9:0] != 10'h000) chk(gw, w);
		if (e[9:0] != 10'h000 && w) chk(gd, wd);
		if (!w && e[9:0] == 10'h000 && !e[12]) chk(busRdata, 32'h0);
		else if (!w && e[9:0] != 10'h000) chk(busRdata, {~a[15:0], a[15:0]});
		@(posedge sys_clk);
		busValid <= 1'b0;
	endtask : acc
	////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		fails++;
		end_of_test();
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk(winBase, 32'h03FF0000);
		chk(bootBankWidth, 2'h2);
		chk(bootWidthBad, 1'b0);
		foreach (rng[g]) begin
			acc(expBase | rng[g][31:16], 1'b0, 4'hF);
			acc(expBase | rng[g][15:0], 1'b1, 4'hF);
			acc(expBase | (rng[g][15:0] + 32'h4), 1'b0, 4'hF);
		end
		acc(expBase | 32'hE402, 1'b0, 4'hF);
		acc(expBase | 32'hE404, 1'b1, 4'h3);
		acc(32'h00001000, 1'b0, 4'hF);
		acc(32'h02000000, 1'b0, 4'hF);
		repeat (150) acc(expBase | ($random(seed) & 32'hFFFC), 1'($random(seed)), 4'hF);
		repeat (50) acc($random(seed) & 32'h03FEFFFC, 1'($random(seed)), 4'hF);
		@(posedge sys_clk);
		remapWe <= 1'b1;
		newWinBase <= 32'h01230000;
		expBase <= 32'h01230000;
		expLimit <= 32'h00FFFFFF;
		@(posedge sys_clk);
		remapWe <= 1'b0;
		#1;
		chk(winBase, 32'h01230000);
		acc(32'h0123EA18, 1'b0, 4'hF);
		acc(32'h03FFE410, 1'b0, 4'hF);
		acc(32'h01240000, 1'b0, 4'hF);
		acc(32'h01800000, 1'b0, 4'hF);
		// host requests are ignored until guest mode is on
		for (int m = 0; m < 2; m++) begin
			@(posedge sys_clk);
			guestMode <= (m == 1);
			hostValid <= 1'b1;
			hostOffset <= 16'h2004;
			sel = 10'h000;
			repeat (3) begin
				@(posedge sys_clk);
				#1;
				if (hostSel) sel |= groupSel;
			end
			chk(sel, (m == 1) ? 10'h002 : 10'h000);
		end
		@(posedge sys_clk);
		hostValid <= 1'b0;
		rst_n <= 1'b0;
		strap <= 2'h0;
		expBase <= 32'h03FF0000;
		expLimit <= 32'h01FFFFFF;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk(winBase, 32'h03FF0000);
		chk(bootWidthBad, 1'b1);
		chk(bootBankWidth, 2'h0);
		acc(32'h03FFE600, 1'b0, 4'hF);
		acc(32'h01800000, 1'b0, 4'hF);
		end_of_test();
	end
endmodule : system_address_map_decoder_tb
`default_nettype wire
